// ==== clock_gate_defs.svh ====
// Constants for the sleep-mode port clock gating block
`ifndef CLOCK_GATE_DEFS_SVH
`define CLOCK_GATE_DEFS_SVH

`define PORT_COUNT          8
`define PORT_MSB            7
`define PORT_INDEX_WIDTH    3
`define APB_ADDR_WIDTH      12
`define APB_DATA_WIDTH      32
`define SLEEP_GATE_OFFSET   12'h118
`define GATE_STATUS_OFFSET  12'h11c
`define SLEEP_GATE_RESET    8'h00
`define RESERVED_LSB        8
`define RESERVED_MSB        31
`define STATUS_MODE_BIT     8
`define BYTE0_STRB          0
`define PORT_A_BIT          0
`define PORT_B_BIT          1
`define PORT_C_BIT          2
`define PORT_D_BIT          3
`define PORT_E_BIT          4
`define PORT_F_BIT          5
`define PORT_G_BIT          6
`define PORT_H_BIT          7

`endif

// ==== clock_gate_pkg.sv ====
// Types for the sleep-mode port clock gating block
package clock_gate_pkg;

    // One-hot gating source
    typedef enum logic [1:0] {
        MODE_RUN   = 2'b01,
        MODE_SLEEP = 2'b10
    } mode_t;

endpackage

// ==== sleep_port_clock_gating.sv ====
// APB register and port clock enables for sleep-mode gating
`timescale 1ns/1ps
`include "clock_gate_defs.svh"

module sleep_port_clock_gating
    import clock_gate_pkg::*;
(
    // Clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         reset,

    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [`APB_ADDR_WIDTH-1:0]   paddr,
    input  wire logic [`APB_DATA_WIDTH-1:0]   pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic      [`APB_DATA_WIDTH-1:0]   prdata,
    output logic                              pready,
    output logic                              pslverr,

    // Power mode and run-mode settings
    input  wire logic                         sleep_active,
    input  wire logic                         auto_clock_gating_select,
    input  wire logic [`PORT_MSB:0]           run_port_clock_gate,

    // Port accesses from the bus matrix
    input  wire logic                         port_req,
    input  wire logic [`PORT_INDEX_WIDTH-1:0] port_req_index,
    output logic                              port_bus_fault,

    // Per-port clock enables
    output logic                              port_a_clock_enable,
    output logic                              port_b_clock_enable,
    output logic                              port_c_clock_enable,
    output logic                              port_d_clock_enable,
    output logic                              port_e_clock_enable,
    output logic                              port_f_clock_enable,
    output logic                              port_g_clock_enable,
    output logic                              port_h_clock_enable
);

    ////////////////////////////////////////////////////////////////////////

    function automatic logic port_gated(
        input logic [`PORT_MSB:0]           pattern,
        input logic [`PORT_INDEX_WIDTH-1:0] idx
    );
        port_gated = ~pattern[idx];
    endfunction

    function automatic logic [`PORT_MSB:0] select_pattern(
        input mode_t              mode,
        input logic [`PORT_MSB:0] sleep_pat,
        input logic [`PORT_MSB:0] run_pat
    );
        unique case (mode)
            MODE_SLEEP: select_pattern = sleep_pat;
            MODE_RUN:   select_pattern = run_pat;
            default:    select_pattern = run_pat;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////

    logic [`PORT_MSB:0]         sleep_q;
    logic [`PORT_MSB:0]         sleep_d;
    logic [`PORT_MSB:0]         gate_q;
    logic [`PORT_MSB:0]         gate_d;
    logic [`APB_DATA_WIDTH-1:0] rdata_q;
    logic [`APB_DATA_WIDTH-1:0] rdata_d;
    logic                       err_q;
    logic                       err_d;
    logic                       fault_q;
    logic                       fault_d;
    mode_t                      mode_q;
    mode_t                      mode_d;

    wire hit_sleep  = (paddr == `SLEEP_GATE_OFFSET);
    wire hit_status = (paddr == `GATE_STATUS_OFFSET);
    wire setup      = psel & ~penable;
    wire access     = psel & penable;
    wire wr_sleep   = access & pwrite & hit_sleep & pstrb[`BYTE0_STRB];

    ////////////////////////////////////////////////////////////////////////
    // Register write

    // Only byte lane 0 carries enables; upper lanes are dropped
    assign sleep_d = wr_sleep ? pwdata[`PORT_MSB:0] : sleep_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sleep_q <= `SLEEP_GATE_RESET;
        end else begin
            sleep_q <= sleep_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured in setup so it is stable all access phase

    wire [`APB_DATA_WIDTH-1:0] sleep_word =
        {{(`RESERVED_MSB-`PORT_MSB){1'b0}}, sleep_q};
    wire [`APB_DATA_WIDTH-1:0] status_word =
        {{(`RESERVED_MSB-`STATUS_MODE_BIT){1'b0}},
         (mode_q == MODE_SLEEP), gate_q};

    assign rdata_d = !setup      ? rdata_q :
                     hit_sleep   ? sleep_word :
                     hit_status  ? status_word :
                                   '0;
    assign err_d   = setup ? ~(hit_sleep | hit_status) : err_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rdata_q <= '0;
            err_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    // Zero wait states keep the companion registers' timing identical
    assign pready  = 1'b1;
    assign prdata  = rdata_q;
    assign pslverr = access & err_q;

    ////////////////////////////////////////////////////////////////////////
    // Gating source and applied pattern

    assign mode_d = (sleep_active & auto_clock_gating_select) ?
                    MODE_SLEEP : MODE_RUN;
    assign gate_d = select_pattern(mode_d, sleep_q, run_port_clock_gate);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mode_q <= MODE_RUN;
            gate_q <= '0;
        end else begin
            mode_q <= mode_d;
            gate_q <= gate_d;
        end
    end

    assign port_a_clock_enable = gate_q[`PORT_A_BIT];
    assign port_b_clock_enable = gate_q[`PORT_B_BIT];
    assign port_c_clock_enable = gate_q[`PORT_C_BIT];
    assign port_d_clock_enable = gate_q[`PORT_D_BIT];
    assign port_e_clock_enable = gate_q[`PORT_E_BIT];
    assign port_f_clock_enable = gate_q[`PORT_F_BIT];
    assign port_g_clock_enable = gate_q[`PORT_G_BIT];
    assign port_h_clock_enable = gate_q[`PORT_H_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Bus fault on access to an unclocked port

    // Judged on the applied pattern, so fault and clock always agree
    assign fault_d = port_req & port_gated(gate_q, port_req_index);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault_d;
        end
    end

    assign port_bus_fault = fault_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_reset_zero;
        $fell(reset) |-> (sleep_q == '0) && (gate_q == '0);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("gating register not zero after reset");

    property p_write_takes;
        wr_sleep |=> (sleep_q == $past(pwdata[`PORT_MSB:0]));
    endproperty
    a_write_takes: assert property (p_write_takes)
        else $error("enable bits did not take written value");

    property p_read_reserved;
        access && !pwrite && hit_sleep |->
            (prdata[`RESERVED_MSB:`RESERVED_LSB] == '0) &&
            (prdata[`PORT_MSB:0] == sleep_q);
    endproperty
    a_read_reserved: assert property (p_read_reserved)
        else $error("read of gating register returned wrong bits");

    property p_sleep_pattern;
        sleep_active && auto_clock_gating_select |=>
            (gate_q == $past(sleep_q)) && (mode_q == MODE_SLEEP);
    endproperty
    a_sleep_pattern: assert property (p_sleep_pattern)
        else $error("sleep pattern not applied in sleep");

    property p_run_outside_sleep;
        !sleep_active |=> (gate_q == $past(run_port_clock_gate));
    endproperty
    a_run_outside_sleep: assert property (p_run_outside_sleep)
        else $error("sleep pattern leaked outside sleep");

    property p_no_auto_gating;
        sleep_active && !auto_clock_gating_select |=>
            (mode_q == MODE_RUN) &&
            (gate_q == $past(run_port_clock_gate));
    endproperty
    a_no_auto_gating: assert property (p_no_auto_gating)
        else $error("run pattern not kept without auto gating");

    property p_all_withheld;
        (sleep_active && auto_clock_gating_select && sleep_q == '0)[*2]
            |-> (gate_q == '0) && !port_a_clock_enable &&
                !port_h_clock_enable;
    endproperty
    a_all_withheld: assert property (p_all_withheld)
        else $error("clock given to a disabled port");

    property p_fault_raised;
        port_req && !gate_q[port_req_index] |=> port_bus_fault;
    endproperty
    a_fault_raised: assert property (p_fault_raised)
        else $error("no bus fault for gated port access");

    property p_fault_only_gated;
        port_bus_fault |->
            $past(port_req) && !$past(gate_q[port_req_index]);
    endproperty
    a_fault_only_gated: assert property (p_fault_only_gated)
        else $error("spurious bus fault");

    property p_unmapped_error;
        access && !(hit_sleep || hit_status) |-> pslverr && pready;
    endproperty
    a_unmapped_error: assert property (p_unmapped_error)
        else $error("unmapped address answered without error");

    property p_mapped_no_error;
        access && (hit_sleep || hit_status) |-> !pslverr;
    endproperty
    a_mapped_no_error: assert property (p_mapped_no_error)
        else $error("mapped address answered with error");

    // Register side
    property p_strobe_masked;
        access && pwrite && hit_sleep && !pstrb[`BYTE0_STRB] |=> $stable(sleep_q);
    endproperty
    a_strobe_masked: assert property (p_strobe_masked)
        else $error("write with lane zero off changed enable bits");

    property p_status_write_ignored;
        access && pwrite && hit_status |=> $stable(sleep_q);
    endproperty
    a_status_write_ignored: assert property (p_status_write_ignored)
        else $error("status write changed enable bits");

    property p_hold_between_writes;
        !wr_sleep |=> (sleep_q == $past(sleep_q));
    endproperty
    a_hold_between_writes: assert property (p_hold_between_writes)
        else $error("enable bits changed without a write");

    // Status read reflects the pattern applied at setup
    property p_status_read;
        access && !pwrite && hit_status |->
            (prdata[`RESERVED_MSB:`STATUS_MODE_BIT+1] == '0) &&
            (prdata[`STATUS_MODE_BIT] == $past(mode_q == MODE_SLEEP)) &&
            (prdata[`PORT_MSB:0] == $past(gate_q));
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read returned wrong bits");

    // Read data only moves on a setup edge
    property p_prdata_held;
        !setup |=> $stable(prdata);
    endproperty
    a_prdata_held: assert property (p_prdata_held)
        else $error("read data moved outside a setup cycle");

    // Gating side
    property p_mode_legal;
        $onehot(mode_q);
    endproperty
    a_mode_legal: assert property (p_mode_legal)
        else $error("gating source not one-hot");

    property p_sleep_mode_source;
        (mode_q == MODE_SLEEP) |-> $past(sleep_active && auto_clock_gating_select);
    endproperty
    a_sleep_mode_source: assert property (p_sleep_mode_source)
        else $error("sleep pattern chosen without sleep and auto gating");

    property p_reset_outputs;
        $fell(reset) |-> !port_bus_fault && (prdata == '0) &&
            !port_b_clock_enable && !port_g_clock_enable;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs)
        else $error("outputs not cleared by reset");

    // Fault side
    property p_no_fault_when_idle;
        !port_req |=> !port_bus_fault;
    endproperty
    a_no_fault_when_idle: assert property (p_no_fault_when_idle)
        else $error("bus fault without a port access");

    property p_no_fault_enabled;
        port_req && gate_q[port_req_index] |=> !port_bus_fault;
    endproperty
    a_no_fault_enabled: assert property (p_no_fault_enabled)
        else $error("bus fault on a clocked port");

endmodule

// ==== sleep_mode_port_clock_gating_tb.sv ====
// Self-checking testbench for the sleep-mode port clock gating block
`timescale 1ns/1ps
`include "clock_gate_defs.svh"

module sleep_mode_port_clock_gating_tb import clock_gate_pkg::*;;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, smp_rd;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, pslverr, smp_err, smp_flt, port_bus_fault;
    logic        sleep_active = 1'b0, auto_gate = 1'b0, port_req = 1'b0;
    logic [7:0]  run_pat = 8'h00;
    logic [2:0]  port_req_index = 3'h0;
    logic [7:0]  en;
    int          error_cnt = 0, total_checks = 0;

    ////////////////////////////////////////////////////////////////////////////
    sleep_port_clock_gating uut (
        .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_active(sleep_active), .auto_clock_gating_select(auto_gate),
        .run_port_clock_gate(run_pat), .port_req(port_req),
        .port_req_index(port_req_index), .port_bus_fault(port_bus_fault),
        .port_a_clock_enable(en[0]), .port_b_clock_enable(en[1]),
        .port_c_clock_enable(en[2]), .port_d_clock_enable(en[3]),
        .port_e_clock_enable(en[4]), .port_f_clock_enable(en[5]),
        .port_g_clock_enable(en[6]), .port_h_clock_enable(en[7]));

    always #25 ref_clk = ~ref_clk;

    // Sampled copies avoid racing the design's own updates at the edge
    always @(posedge ref_clk) begin
        smp_rd <= prdata;
        smp_err <= pslverr;
        smp_flt <= port_bus_fault;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [31:0] exp, input logic err);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
        if (!wr) chk(smp_rd, exp);
        chk({31'h0, smp_err}, {31'h0, err});
        if (n >= 20) begin
            error_cnt++;
            finish_test();
        end
    endtask

    // Enables are registered, so they follow the inputs one edge later
    task automatic mode(input logic s, input logic g, input logic [7:0] r,
                        input logic [7:0] exp);
        @(posedge ref_clk);
        sleep_active <= s;
        auto_gate <= g;
        run_pat <= r;
        @(posedge ref_clk);
        #1;
        chk({24'h0, en}, {24'h0, exp});
    endtask

    task automatic poke(input logic [2:0] i, input logic f);
        @(posedge ref_clk);
        port_req <= 1'b1;
        port_req_index <= i;
        #1;
        chk({31'h0, smp_flt}, 32'h0);
        @(posedge ref_clk);
        port_req <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk({31'h0, smp_flt}, {31'h0, f});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        #1 chk({24'h0, en}, 32'h0);
        xfer(1'b0, 12'h118, 32'h0, 4'hf, 32'h0, 1'b0);
        xfer(1'b1, 12'h118, 32'hffff_ffa5, 4'hf, 32'h0, 1'b0);
        xfer(1'b0, 12'h118, 32'h0, 4'hf, 32'h0000_00a5, 1'b0);
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, 12'h118, 32'h1 << i, 4'hf, 32'h0, 1'b0);
            mode(1'b1, 1'b1, ~(8'h1 << i), 8'h1 << i);
            xfer(1'b0, 12'h11c, 32'h0, 4'hf, {23'h0, 1'b1, 8'h1 << i}, 1'b0);
            for (int j = 0; j < 8; j++) poke(j[2:0], i != j);
        end
        mode(1'b1, 1'b0, 8'h3c, 8'h3c);
        poke(3'h0, 1'b1);
        poke(3'h2, 1'b0);
        mode(1'b0, 1'b1, 8'hc3, 8'hc3);
        xfer(1'b0, 12'h11c, 32'h0, 4'hf, 32'h0000_00c3, 1'b0);
        // Lane zero disabled: the register keeps its old pattern
        xfer(1'b1, 12'h118, 32'h0000_005a, 4'h0, 32'h0, 1'b0);
        xfer(1'b0, 12'h118, 32'h0, 4'hf, 32'h0000_0080, 1'b0);
        xfer(1'b1, 12'h11c, 32'h0000_01ff, 4'hf, 32'h0, 1'b0);
        xfer(1'b0, 12'h11c, 32'h0, 4'hf, 32'h0000_00c3, 1'b0);
        xfer(1'b1, 12'h040, 32'h0000_00ff, 4'hf, 32'h0, 1'b1);
        xfer(1'b0, 12'h040, 32'h0, 4'hf, 32'h0, 1'b1);
        xfer(1'b0, 12'h118, 32'h0, 4'hf, 32'h0000_0080, 1'b0);
        mode(1'b1, 1'b1, 8'h00, 8'h80);
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        #1 chk({24'h0, en}, 32'h0);
        xfer(1'b0, 12'h118, 32'h0, 4'hf, 32'h0, 1'b0);
        finish_test();
    end
endmodule
